// file: clock_reset_defines.vh
// register offsets, field positions, reset values and timing constants
// for the clock select, prescale and reset block; definitions only
`ifndef CLOCK_RESET_DEFINES_VH
`define CLOCK_RESET_DEFINES_VH

`define ADDR_CLOCK_RESET_CONTROL     24'hFFFC40
`define ADDR_FAST_CLOCK_PRESCALER    24'hFFFC42
`define ADDR_SLOW_CLOCK_PRESCALER    24'hFFFC44
`define ADDR_AUX_CLOCK_PRESCALER     24'hFFFC46

`define CTRL_SLOW_SEL_BIT            0
`define CTRL_FAST_SEL_BIT            1
`define CTRL_PLL_PD_BIT              2
`define CTRL_AUX_ONE_EN_BIT          3
`define CTRL_AUX_TWO_EN_BIT          4
`define CTRL_POWER_ON_BIT            5

`define FAST_PRESCALER_RESET         8'h4F
`define SLOW_PRESCALER_RESET         8'hB6
`define AUX_PRESCALER_RESET          8'hFF
`define FAST_PRESCALER_MASK          8'h7F

`define PLL_MODE_X3                  3'h3
`define PLL_MODE_X4                  3'h4
`define PLL_MODE_X5                  3'h5

`define POR_PRESET                   14'h3FFF

`endif

// file: clock_select_prescale_reset.v
// clock selection, prescaling and reset generation, one clock domain
// assumes mclk_in is the main clock; oscillator, pll analog core and
// power management sit outside and join through plain ports
//
// Summary of operation
// - fast divide by fast_divisor plus one
// - fast select 0 pll, 1 main; resets 1
// - ignore pll select while powered down/unlocked
// - ignore power-down set while pll selected
// - power-down bit 1 holds pll stopped
// - slow select 0 prescaled main, 1 oscillator
// - slow divide by 2*(divisor+1); reset B6h
// - aux one runs if enabled and main stable
// - aux two runs if enabled and main stable
// - aux divide by field plus one; reset FFh
// - 14-bit power-on counter holds internal reset
// - power-on flag set; write 0 clears only
// - external reset low asserts internal reset
// - pll mode 011/100/101 gives x3/x4/x5
// - fast prescaler resets 4Fh unless programming
// - fast select clears only after pll lock
// - oscillator selected only when seen toggling
//
// The implementer's own choice: strobed register access.
`include "clock_reset_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module clock_select_prescale_reset
#(
  parameter        ADDR_WIDTH = 24,
  parameter [13:0] POR_COUNT  = `POR_PRESET
)
(
  input  wire                  mclk_in,
  input  wire                  reset_n_in,
  input  wire                  clk_en_in,
  input  wire                  ext_reset_n_in,
  input  wire                  prog_mode_in,
  input  wire                  pll_locked_in,
  input  wire                  pmm_stop_pll_in,
  input  wire                  main_clock_good_in,
  input  wire                  slow_osc_in,
  input  wire                  pll_clk_in,
  input  wire [ADDR_WIDTH-1:0] addr_in,
  input  wire [7:0]            wdata_in,
  input  wire                  wr_in,
  input  wire                  rd_in,
  output reg  [7:0]            rdata_out,
  output reg                   sys_reset_out,
  output reg                   stop_pll_out,
  output reg  [2:0]            pll_mode_out,
  output reg                   pll_mult_valid_out,
  output reg                   sys_clk_out,
  output reg                   slow_clk_out,
  output reg                   aux_one_clk_out,
  output reg                   aux_two_clk_out
);

  reg        slow_source_select;
  reg        fast_source_select;
  reg        pll_power_down;
  reg        aux_one_enable;
  reg        aux_two_enable;
  reg        power_on_flag;
  reg  [7:0] fast_clock_prescaler;
  reg  [7:0] slow_clock_prescaler;
  reg  [7:0] auxiliary_clock_prescaler;
  reg  [13:0] por_count;
  reg        ext_reset_sync1;
  reg        ext_reset_sync2;
  reg        prog_latched;
  reg        prog_taken;
  reg  [1:0] osc_hist;
  reg  [7:0] osc_age;
  reg        fast_pll_src_d;
  reg        pll_src_d;
  reg  [3:0] fast_cnt;
  reg  [7:0] slow_cnt;
  reg        slow_div_clk;
  reg  [3:0] aux_one_cnt;
  reg  [3:0] aux_two_cnt;

  wire       ctrl_hit   = (addr_in == `ADDR_CLOCK_RESET_CONTROL);
  wire       fast_hit   = (addr_in == `ADDR_FAST_CLOCK_PRESCALER);
  wire       slow_hit   = (addr_in == `ADDR_SLOW_CLOCK_PRESCALER);
  wire       aux_hit    = (addr_in == `ADDR_AUX_CLOCK_PRESCALER);
  wire       osc_toggling = (osc_age != 8'h00);
  wire [3:0] fast_divisor    = fast_clock_prescaler[3:0];
  wire [2:0] pll_mode        = fast_clock_prescaler[6:4];
  wire [7:0] slow_divisor    = slow_clock_prescaler;
  wire [3:0] aux_one_divisor = auxiliary_clock_prescaler[3:0];
  wire [3:0] aux_two_divisor = auxiliary_clock_prescaler[7:4];
  wire       sel_pll = !fast_source_select;

  // clock level for a divide-by-(n+1) counter: high for the first half
  function div_high;
    input [3:0] cnt;
    input [3:0] lim;
    begin
      div_high = (cnt <= {1'b0, lim[3:1]});
    end
  endfunction

  // divide-by-(n+1) counter step, used by the fast and both aux prescalers; the slow one has its own counter
  function [3:0] next_div4;
    input [3:0] cnt;
    input [3:0] lim;
    begin
      if (cnt >= lim)
        next_div4 = 4'h0;
      else
        next_div4 = cnt + 4'h1;
    end
  endfunction

  // power-on counter and external reset
  always @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      por_count       <= POR_COUNT;
      ext_reset_sync1 <= 1'b0;
      ext_reset_sync2 <= 1'b0;
      sys_reset_out   <= 1'b1;
    end
    else if (clk_en_in)
    begin
      ext_reset_sync1 <= ext_reset_n_in;
      ext_reset_sync2 <= ext_reset_sync1;
      if (por_count != 14'h0000)
        por_count <= por_count - 14'h0001;
      sys_reset_out <= (por_count != 14'h0000) || !ext_reset_sync2;
    end
  end

  // software registers
  always @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      slow_source_select        <= 1'b0;
      fast_source_select        <= 1'b1;
      pll_power_down            <= 1'b1;
      aux_one_enable            <= 1'b0;
      aux_two_enable            <= 1'b0;
      power_on_flag             <= 1'b1;
      fast_clock_prescaler      <= `FAST_PRESCALER_RESET;
      slow_clock_prescaler      <= `SLOW_PRESCALER_RESET;
      auxiliary_clock_prescaler <= `AUX_PRESCALER_RESET;
      prog_taken                <= 1'b0;
      prog_latched              <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (!prog_taken)
      begin
        prog_taken   <= 1'b1;
        prog_latched <= prog_mode_in;
        if (prog_mode_in)
          fast_clock_prescaler <= 8'h00;
      end
      if (wr_in && ctrl_hit)
      begin
        if (!wdata_in[`CTRL_SLOW_SEL_BIT] || osc_toggling)
          slow_source_select <= wdata_in[`CTRL_SLOW_SEL_BIT];
        if (wdata_in[`CTRL_FAST_SEL_BIT])
          fast_source_select <= 1'b1;
        else if (!pll_power_down && pll_locked_in)
          fast_source_select <= 1'b0;
        if (!wdata_in[`CTRL_PLL_PD_BIT])
          pll_power_down <= 1'b0;
        else if (fast_source_select)
          pll_power_down <= 1'b1;
        aux_one_enable <= wdata_in[`CTRL_AUX_ONE_EN_BIT];
        aux_two_enable <= wdata_in[`CTRL_AUX_TWO_EN_BIT];
        if (!wdata_in[`CTRL_POWER_ON_BIT])
          power_on_flag <= 1'b0;
      end
      if (wr_in && fast_hit)
        fast_clock_prescaler <= wdata_in & `FAST_PRESCALER_MASK;
      if (wr_in && slow_hit)
        slow_clock_prescaler <= wdata_in;
      if (wr_in && aux_hit)
        auxiliary_clock_prescaler <= wdata_in;
      // fall back to the prescaler if the oscillator stops
      if (slow_source_select && !osc_toggling)
        slow_source_select <= 1'b0;
    end
  end

  // read port, data stand one cycle after the strobe
  always @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      rdata_out <= 8'h00;
    else if (clk_en_in)
    begin
      if (rd_in && ctrl_hit)
        rdata_out <= {2'b00, power_on_flag, aux_two_enable, aux_one_enable,
                      pll_power_down, fast_source_select, slow_source_select};
      else if (rd_in && fast_hit)
        rdata_out <= fast_clock_prescaler;
      else if (rd_in && slow_hit)
        rdata_out <= slow_clock_prescaler;
      else if (rd_in && aux_hit)
        rdata_out <= auxiliary_clock_prescaler;
      else
        rdata_out <= 8'h00;
    end
  end

  // oscillator activity detect and pll control
  always @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      osc_hist           <= 2'b00;
      osc_age            <= 8'h00;
      stop_pll_out       <= 1'b1;
      pll_mode_out       <= `PLL_MODE_X4;
      pll_mult_valid_out <= 1'b1;
    end
    else if (clk_en_in)
    begin
      osc_hist <= {osc_hist[0], slow_osc_in};
      if (osc_hist[1] != osc_hist[0])
        osc_age <= 8'hFF;
      else if (osc_age != 8'h00)
        osc_age <= osc_age - 8'h01;
      stop_pll_out <= pll_power_down || pmm_stop_pll_in;
      pll_mode_out <= pll_mode;
      pll_mult_valid_out <= (pll_mode == `PLL_MODE_X3) || (pll_mode == `PLL_MODE_X4) ||
                            (pll_mode == `PLL_MODE_X5);
    end
  end

  // prescalers; fast path counts on the main clock as a gating enable
  always @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      fast_cnt        <= 4'h0;
      slow_cnt        <= 8'h00;
      slow_div_clk    <= 1'b0;
      aux_one_cnt     <= 4'h0;
      aux_two_cnt     <= 4'h0;
      sys_clk_out     <= 1'b0;
      slow_clk_out    <= 1'b0;
      aux_one_clk_out <= 1'b0;
      aux_two_clk_out <= 1'b0;
      pll_src_d       <= 1'b0;
      fast_pll_src_d  <= 1'b0;
    end
    else if (clk_en_in)
    begin
      pll_src_d      <= pll_clk_in;
      fast_pll_src_d <= pll_src_d;
      fast_cnt       <= next_div4(fast_cnt, fast_divisor);
      sys_clk_out    <= sel_pll ? fast_pll_src_d : div_high(fast_cnt, fast_divisor);
      if (slow_cnt >= slow_divisor)
      begin
        slow_cnt     <= 8'h00;
        slow_div_clk <= !slow_div_clk;
      end
      else
        slow_cnt <= slow_cnt + 8'h01;
      slow_clk_out <= slow_source_select ? osc_hist[1] : slow_div_clk;
      if (aux_one_enable && main_clock_good_in)
      begin
        aux_one_cnt     <= next_div4(aux_one_cnt, aux_one_divisor);
        aux_one_clk_out <= div_high(aux_one_cnt, aux_one_divisor);
      end
      else
      begin
        aux_one_cnt     <= 4'h0;
        aux_one_clk_out <= 1'b0;
      end
      if (aux_two_enable && main_clock_good_in)
      begin
        aux_two_cnt     <= next_div4(aux_two_cnt, aux_two_divisor);
        aux_two_clk_out <= div_high(aux_two_cnt, aux_two_divisor);
      end
      else
      begin
        aux_two_cnt     <= 4'h0;
        aux_two_clk_out <= 1'b0;
      end
    end
  end

endmodule // clock_select_prescale_reset

`default_nettype wire

// file: clock_select_prescale_reset_properties.sv
// checker for the clock select, prescale and reset block
// sees only top-level ports; bound to the block below
`timescale 1ns/100ps
`default_nettype none
module csr_checker #(parameter [13:0] POR_COUNT = 14'h3FFF)
(
  input wire logic       mclk_in,
  input wire logic       reset_n_in,
  input wire logic       ext_reset_n_in,
  input wire logic       pmm_stop_pll_in,
  input wire logic       main_clock_good_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       sys_reset_out,
  input wire logic       stop_pll_out,
  input wire logic [2:0] pll_mode_out,
  input wire logic       pll_mult_valid_out,
  input wire logic       aux_one_clk_out,
  input wire logic       aux_two_clk_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  sequence pin_low; !ext_reset_n_in [*4]; endsequence
  sequence main_bad; !main_clock_good_in [*3]; endsequence
  read_idle_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data not idle");
  ext_hold_a: assert property (pin_low |=> sys_reset_out)
    else $error("reset not held by pin");
  reset_stays_a: assert property (ext_reset_n_in [*4] ##0 !sys_reset_out |=> !sys_reset_out)
    else $error("reset came back");
  por_hold_a: assert property ($rose(reset_n_in) |-> sys_reset_out [*8])
    else $error("power-on reset too short");
  mode_valid_a: assert property
    (pll_mult_valid_out == (pll_mode_out inside {3'h3, 3'h4, 3'h5}))
    else $error("multiplier valid wrong");
  pmm_stop_a: assert property (pmm_stop_pll_in [*2] |-> stop_pll_out)
    else $error("pll stop missing");
  aux_one_off_a: assert property (main_bad |-> $stable(aux_one_clk_out))
    else $error("aux one runs on bad clock");
  aux_two_off_a: assert property (main_bad |-> $stable(aux_two_clk_out))
    else $error("aux two runs on bad clock");
endmodule // csr_checker

bind clock_select_prescale_reset csr_checker #(.POR_COUNT(POR_COUNT)) i_csr_checker (
  .mclk_in(mclk_in), .reset_n_in(reset_n_in), .ext_reset_n_in(ext_reset_n_in),
  .pmm_stop_pll_in(pmm_stop_pll_in), .main_clock_good_in(main_clock_good_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .sys_reset_out(sys_reset_out),
  .stop_pll_out(stop_pll_out), .pll_mode_out(pll_mode_out),
  .pll_mult_valid_out(pll_mult_valid_out), .aux_one_clk_out(aux_one_clk_out),
  .aux_two_clk_out(aux_two_clk_out));
`default_nettype wire

// file: clock_select_prescale_reset_tb.sv
// self-checking bench for the clock select, prescale and reset block
// drives every port directly; no partner model
`timescale 1ns/100ps
`default_nettype none
module clock_select_prescale_reset_tb;
  logic        mclk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        ext_n = 1'b1;
  logic        lock = 1'b0;
  logic        pmm = 1'b0;
  logic        good = 1'b0;
  logic        osc = 1'b0;
  logic        osc_run = 1'b0;
  logic        prog = 1'b0;
  logic [23:0] addr = 24'h000000;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  wire  [7:0]  rdata;
  wire  [2:0]  mode;
  wire         sys_rst, stop_pll, valid;
  wire  [3:0]  clks;
  int          err_count = 0;
  int          comparisons = 0;
  int          d, i;

  clock_select_prescale_reset #(.POR_COUNT(14'h0010)) i_dut (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .clk_en_in(1'b1),
    .ext_reset_n_in(ext_n), .prog_mode_in(prog), .pll_locked_in(lock),
    .pmm_stop_pll_in(pmm), .main_clock_good_in(good), .slow_osc_in(osc),
    .pll_clk_in(1'b0), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .sys_reset_out(sys_rst), .stop_pll_out(stop_pll),
    .pll_mode_out(mode), .pll_mult_valid_out(valid), .sys_clk_out(clks[3]),
    .slow_clk_out(clks[2]), .aux_one_clk_out(clks[1]), .aux_two_clk_out(clks[0]));

  always #50 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (osc_run) osc <= ~osc;

  function automatic int exp_per(input int k, input int dv);
    return (k == 2) ? 2 * (dv + 1) : dv + 1;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [23:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
    @(posedge mclk_in);
  endtask

  task automatic rd_reg(input logic [23:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    @(negedge mclk_in);
    check(rdata, e);
    @(posedge mclk_in);
  endtask

  // period between the second and third rising edge; 0 if it never runs
  task automatic per(input int k, input int e);
    int n, r;
    logic p;
    n = 0;
    r = 0;
    p = clks[k];
    for (int t = 0; t < 1200 && r < 3; t++)
    begin
      @(negedge mclk_in);
      if (clks[k] && !p) r++;
      if (r == 2) n++;
      p = clks[k];
    end
    check(n[7:0], e[7:0]);
    @(posedge mclk_in);
  endtask

  task automatic wait_release;
    for (i = 0; i < 100 && sys_rst !== 1'b0; i++) @(negedge mclk_in);
    check({7'h00, sys_rst}, 8'h00);
    @(posedge mclk_in);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #3000000;
    err_count++;
    report_and_stop;
  end

  initial
  begin
    void'($urandom(61437));
    repeat (3) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    wait_release;
    rd_reg(24'hFFFC40, 8'h26);
    rd_reg(24'hFFFC42, 8'h4F);
    rd_reg(24'hFFFC44, 8'hB6);
    rd_reg(24'hFFFC46, 8'hFF);
    rd_reg(24'hFFFC48, 8'h00);
    for (d = 0; d < 8; d++)
    begin
      wr_reg(24'hFFFC42, {1'b1, d[2:0], 4'h1});
      rd_reg(24'hFFFC42, {1'b0, d[2:0], 4'h1});
      check({5'h00, mode}, {5'h00, d[2:0]});
      check({7'h00, valid}, {7'h00, d >= 3 && d <= 5});
    end
    wr_reg(24'hFFFC40, 8'h3C);
    rd_reg(24'hFFFC40, 8'h3E);
    per(1, 0);
    per(0, 0);
    good <= 1'b1;
    repeat (4)
    begin
      d = 1 + $urandom % 15;
      wr_reg(24'hFFFC42, {4'h4, d[3:0]});
      per(3, exp_per(3, d));
      d = $urandom % 40;
      wr_reg(24'hFFFC44, d[7:0]);
      per(2, exp_per(2, d));
      d = 32'h11 | ($urandom & 32'hEE);
      wr_reg(24'hFFFC46, d[7:0]);
      rd_reg(24'hFFFC46, d[7:0]);
      per(1, exp_per(1, d % 16));
      per(0, exp_per(0, d / 16));
    end
    wr_reg(24'hFFFC40, 8'h18);
    rd_reg(24'hFFFC40, 8'h1A);
    check({7'h00, stop_pll}, 8'h00);
    pmm <= 1'b1;
    repeat (3) @(posedge mclk_in);
    check({7'h00, stop_pll}, 8'h01);
    pmm <= 1'b0;
    lock <= 1'b1;
    wr_reg(24'hFFFC40, 8'h18);
    rd_reg(24'hFFFC40, 8'h18);
    wr_reg(24'hFFFC40, 8'h1C);
    rd_reg(24'hFFFC40, 8'h18);
    wr_reg(24'hFFFC40, 8'h1E);
    rd_reg(24'hFFFC40, 8'h1A);
    wr_reg(24'hFFFC40, 8'h1E);
    rd_reg(24'hFFFC40, 8'h1E);
    check({7'h00, stop_pll}, 8'h01);
    wr_reg(24'hFFFC40, 8'h1F);
    rd_reg(24'hFFFC40, 8'h1E);
    osc_run <= 1'b1;
    repeat (4) @(posedge mclk_in);
    wr_reg(24'hFFFC40, 8'h1F);
    rd_reg(24'hFFFC40, 8'h1F);
    ext_n <= 1'b0;
    repeat (5) @(posedge mclk_in);
    @(negedge mclk_in);
    check({7'h00, sys_rst}, 8'h01);
    ext_n <= 1'b1;
    wait_release;
    prog <= 1'b1;
    reset_n_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    wait_release;
    rd_reg(24'hFFFC42, 8'h00);
    rd_reg(24'hFFFC40, 8'h26);
    report_and_stop;
  end
endmodule // clock_select_prescale_reset_tb
`default_nettype wire
